// ==== rtl/pfcg_device_end.sv ====
// device end: pad function select, clock gates and clock output mux
`timescale 1ns/1ns
`default_nettype none
`include "pfcg_defs.svh"
module pfcg_device_end
  import pfcg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // clock output control
  input wire logic [4:0] clock_out_select_i,
  input wire logic clock_out_disable_i,
  output logic clock_out_signal_o,
  // link
  pfcg_if.dev lnk
);
  pfcg_word_t pad_sel_reg, pad_sel_next;
  pfcg_word_t clk_gate_reg, clk_gate_next;
  pfcg_word_t rdata_reg, rdata_next;
  logic clock_out_signal_reg, clock_out_signal_next;
  logic clk_pick;
  logic [9:0] po, poe;
  logic [15:0] s;
  logic [9:0] en;
  logic [9:0] pin;
  // register writes, reserved bits masked
  always_comb begin
    pad_sel_next = pad_sel_reg;
    clk_gate_next = clk_gate_reg;
    rdata_next = 16'h0000;
    if (reg_wr_i && reg_addr_i == `PFCG_OFS_PAD_SEL) begin
      pad_sel_next = reg_wdata_i & `PFCG_PAD_SEL_MASK;
    end
    if (reg_wr_i && reg_addr_i == `PFCG_OFS_CLK_GATE) begin
      clk_gate_next = reg_wdata_i & `PFCG_CLK_GATE_MASK;
    end
    if (reg_rd_i && reg_addr_i == `PFCG_OFS_PAD_SEL) begin
      rdata_next = pad_sel_reg;
    end
    if (reg_rd_i && reg_addr_i == `PFCG_OFS_CLK_GATE) begin
      rdata_next = clk_gate_reg;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_sel_reg <= `PFCG_RST_VAL;
      clk_gate_reg <= `PFCG_RST_VAL;
      rdata_reg <= `PFCG_RST_VAL;
    end else begin
      pad_sel_reg <= pad_sel_next;
      clk_gate_reg <= clk_gate_next;
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata_o = rdata_reg;
  // clock controls straight from the registers
  assign lnk.timer_rate_3x = pad_sel_reg[`PFCG_BIT_TIMER_RATE];
  assign lnk.pwm_rate_3x = pad_sel_reg[`PFCG_BIT_PWM_RATE];
  assign lnk.clk_enable = {clk_gate_reg[`PFCG_BIT_I2C], clk_gate_reg[`PFCG_BIT_ADC],
    clk_gate_reg[`PFCG_BIT_TMR], clk_gate_reg[`PFCG_BIT_UART],
    clk_gate_reg[`PFCG_BIT_SPI], clk_gate_reg[`PFCG_BIT_PWM]};
  // clock pick, sampled; a test path, so glitches at switch are accepted
  always_comb begin
    clk_pick = 1'b0;
    case (clock_out_select_i)
      `PFCG_SEL_SYS: clk_pick = lnk.clk_sys;
      `PFCG_SEL_MOSC: clk_pick = lnk.clk_mosc;
      `PFCG_SEL_ADC: clk_pick = lnk.clk_adc;
      `PFCG_SEL_JTAG: clk_pick = lnk.clk_jtag;
      `PFCG_SEL_PER: clk_pick = lnk.clk_per;
      `PFCG_SEL_PERN: clk_pick = ~lnk.clk_per;
      `PFCG_SEL_HSPER: clk_pick = lnk.clk_hsper;
      default: clk_pick = 1'b0;
    endcase
    clock_out_signal_next = clock_out_disable_i ? 1'b0 : clk_pick;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_out_signal_reg <= 1'b0;
    end else begin
      clock_out_signal_reg <= clock_out_signal_next;
    end
  end
  assign clock_out_signal_o = clock_out_signal_reg;
  // pad output routing, index 0..7 port b, 8 a4, 9 a5
  assign s = pad_sel_reg;
  assign en = lnk.periph_en;
  assign pin = lnk.pad_in & en;
  always_comb begin
    po[7] = s[`PFCG_BIT_B7] ? lnk.i2c_scl_out : lnk.uart_tx;
    poe[7] = s[`PFCG_BIT_B7] ? lnk.i2c_scl_oe : 1'b1;
    po[6] = s[`PFCG_BIT_B6] ? lnk.i2c_sda_out : 1'b0;
    poe[6] = s[`PFCG_BIT_B6] ? lnk.i2c_sda_oe : 1'b0;
    po[5] = s[`PFCG_BIT_B5] ? 1'b0 : lnk.tmr_out[1];
    poe[5] = s[`PFCG_BIT_B5] ? 1'b0 : lnk.tmr_oe[1];
    po[4] = s[`PFCG_BIT_B4] ? clock_out_signal_reg : lnk.tmr_out[0];
    poe[4] = s[`PFCG_BIT_B4] ? 1'b1 : lnk.tmr_oe[0];
    po[3] = s[`PFCG_BIT_B3] ? lnk.tmr_out[3] : lnk.spi_mosi_out;
    poe[3] = s[`PFCG_BIT_B3] ? lnk.tmr_oe[3] : lnk.spi_mosi_oe;
    po[2] = s[`PFCG_BIT_B2] ? lnk.tmr_out[2] : lnk.spi_miso_out;
    poe[2] = s[`PFCG_BIT_B2] ? lnk.tmr_oe[2] : lnk.spi_miso_oe;
    po[1] = s[`PFCG_BIT_B1] ? lnk.i2c_sda_out : 1'b0;
    poe[1] = s[`PFCG_BIT_B1] ? lnk.i2c_sda_oe : 1'b0;
    po[0] = s[`PFCG_BIT_B0] ? lnk.i2c_scl_out : lnk.spi_sclk_out;
    poe[0] = s[`PFCG_BIT_B0] ? lnk.i2c_scl_oe : lnk.spi_sclk_oe;
    unique case (s[`PFCG_A4_HI:`PFCG_A4_LO])
      `PFCG_A_FAULT: begin
        po[8] = 1'b0;
        poe[8] = 1'b0;
      end
      `PFCG_A_TIMER: begin
        po[8] = lnk.tmr_out[2];
        poe[8] = lnk.tmr_oe[2];
      end
      default: begin
        po[8] = lnk.pwm_out[0];
        poe[8] = 1'b1;
      end
    endcase
    unique case (s[`PFCG_A5_HI:`PFCG_A5_LO])
      `PFCG_A_FAULT: begin
        po[9] = 1'b0;
        poe[9] = 1'b0;
      end
      `PFCG_A_TIMER: begin
        po[9] = lnk.tmr_out[3];
        poe[9] = lnk.tmr_oe[3];
      end
      default: begin
        po[9] = lnk.pwm_out[1];
        poe[9] = 1'b1;
      end
    endcase
  end
  // gpio enable has final say over the pad
  assign lnk.pad_out = po & en;
  assign lnk.pad_oe = poe & en;
  // peripheral inputs; shared signals are ored across pads
  assign lnk.uart_rx = pin[6] & ~s[`PFCG_BIT_B6];
  assign lnk.i2c_scl_in = (pin[7] & s[`PFCG_BIT_B7]) | (pin[0] & s[`PFCG_BIT_B0]);
  assign lnk.i2c_sda_in = (pin[6] & s[`PFCG_BIT_B6]) | (pin[1] & s[`PFCG_BIT_B1]);
  assign lnk.tmr_in[0] = pin[4] & ~s[`PFCG_BIT_B4];
  assign lnk.tmr_in[1] = pin[5] & ~s[`PFCG_BIT_B5];
  assign lnk.tmr_in[2] = (pin[2] & s[`PFCG_BIT_B2])
    | (pin[8] & (s[`PFCG_A4_HI:`PFCG_A4_LO] == `PFCG_A_TIMER));
  assign lnk.tmr_in[3] = (pin[3] & s[`PFCG_BIT_B3])
    | (pin[9] & (s[`PFCG_A5_HI:`PFCG_A5_LO] == `PFCG_A_TIMER));
  assign lnk.pwm_fault[0] = pin[8] & (s[`PFCG_A4_HI:`PFCG_A4_LO] == `PFCG_A_FAULT);
  assign lnk.pwm_fault[1] = pin[9] & (s[`PFCG_A5_HI:`PFCG_A5_LO] == `PFCG_A_FAULT);
  assign lnk.pwm_fault[2] = pin[5] & s[`PFCG_BIT_B5];
  assign lnk.spi_mosi_in = pin[3] & ~s[`PFCG_BIT_B3];
  assign lnk.spi_miso_in = pin[2] & ~s[`PFCG_BIT_B2];
  assign lnk.spi_ss_in = pin[1] & ~s[`PFCG_BIT_B1];
  assign lnk.spi_sclk_in = pin[0] & ~s[`PFCG_BIT_B0];
endmodule // pfcg_device_end
`default_nettype wire

// ==== rtl/pfcg_defs.svh ====
// constants for the pin function and clock gate block
`ifndef PFCG_DEFS_SVH
`define PFCG_DEFS_SVH
`define PFCG_OFS_PAD_SEL 4'h0b
`define PFCG_OFS_CLK_GATE 4'h0c
`define PFCG_RST_VAL 16'h0000
`define PFCG_PAD_SEL_MASK 16'hcfff
`define PFCG_CLK_GATE_MASK 16'ha055
`define PFCG_BIT_TIMER_RATE 15
`define PFCG_BIT_PWM_RATE 14
`define PFCG_BIT_B7 11
`define PFCG_BIT_B6 10
`define PFCG_BIT_B5 9
`define PFCG_BIT_B4 8
`define PFCG_BIT_B3 7
`define PFCG_BIT_B2 6
`define PFCG_BIT_B1 5
`define PFCG_BIT_B0 4
`define PFCG_A5_HI 3
`define PFCG_A5_LO 2
`define PFCG_A4_HI 1
`define PFCG_A4_LO 0
`define PFCG_BIT_I2C 15
`define PFCG_BIT_ADC 13
`define PFCG_BIT_TMR 6
`define PFCG_BIT_UART 4
`define PFCG_BIT_SPI 2
`define PFCG_BIT_PWM 0
`define PFCG_SEL_SYS 5'h00
`define PFCG_SEL_MOSC 5'h09
`define PFCG_SEL_ADC 5'h0b
`define PFCG_SEL_JTAG 5'h0c
`define PFCG_SEL_PER 5'h0d
`define PFCG_SEL_PERN 5'h0e
`define PFCG_SEL_HSPER 5'h0f
`define PFCG_A_FAULT 2'h2
`define PFCG_A_TIMER 2'h3
`endif

// ==== rtl/pfcg_pkg.sv ====
// types for the pin function and clock gate block
package pfcg_pkg;
  typedef logic [15:0] pfcg_word_t;
  typedef logic [4:0] pfcg_clksel_t;
  typedef logic [3:0] pfcg_addr_t;
endpackage

// ==== rtl/pfcg_if.sv ====
// link between the pin function block and its peripheral and pad side
`timescale 1ns/1ns
`default_nettype none
interface pfcg_if;
  // peripheral clock sources
  logic clk_sys;
  logic clk_mosc;
  logic clk_adc;
  logic clk_jtag;
  logic clk_per;
  logic clk_hsper;
  // pad handover and pad levels, bits 7..0 port b, 9..8 port a pins 5..4
  logic [9:0] periph_en;
  logic [9:0] pad_in;
  logic [9:0] pad_out;
  logic [9:0] pad_oe;
  // peripheral signals
  logic uart_tx;
  logic uart_rx;
  logic i2c_scl_out;
  logic i2c_scl_oe;
  logic i2c_scl_in;
  logic i2c_sda_out;
  logic i2c_sda_oe;
  logic i2c_sda_in;
  logic [3:0] tmr_out;
  logic [3:0] tmr_oe;
  logic [3:0] tmr_in;
  logic [2:0] pwm_fault;
  logic [1:0] pwm_out;
  logic spi_mosi_out;
  logic spi_mosi_oe;
  logic spi_mosi_in;
  logic spi_miso_out;
  logic spi_miso_oe;
  logic spi_miso_in;
  logic spi_ss_in;
  logic spi_sclk_out;
  logic spi_sclk_oe;
  logic spi_sclk_in;
  // clock controls
  logic [5:0] clk_enable;
  logic timer_rate_3x;
  logic pwm_rate_3x;
  modport dev (
    input clk_sys, clk_mosc, clk_adc, clk_jtag, clk_per, clk_hsper,
    input periph_en, pad_in, uart_tx, i2c_scl_out, i2c_scl_oe, i2c_sda_out,
    input i2c_sda_oe, tmr_out, tmr_oe, pwm_out, spi_mosi_out, spi_mosi_oe,
    input spi_miso_out, spi_miso_oe, spi_sclk_out, spi_sclk_oe,
    output pad_out, pad_oe, uart_rx, i2c_scl_in, i2c_sda_in, tmr_in,
    output pwm_fault, spi_mosi_in, spi_miso_in, spi_ss_in, spi_sclk_in,
    output clk_enable, timer_rate_3x, pwm_rate_3x
  );
  modport per (
    output clk_sys, clk_mosc, clk_adc, clk_jtag, clk_per, clk_hsper,
    output periph_en, pad_in, uart_tx, i2c_scl_out, i2c_scl_oe, i2c_sda_out,
    output i2c_sda_oe, tmr_out, tmr_oe, pwm_out, spi_mosi_out, spi_mosi_oe,
    output spi_miso_out, spi_miso_oe, spi_sclk_out, spi_sclk_oe,
    input pad_out, pad_oe, uart_rx, i2c_scl_in, i2c_sda_in, tmr_in,
    input pwm_fault, spi_mosi_in, spi_miso_in, spi_ss_in, spi_sclk_in,
    input clk_enable, timer_rate_3x, pwm_rate_3x
  );
endinterface
`default_nettype wire

// ==== rtl/pfcg_periph_end.sv ====
// peripheral and pad side end: drives sources, keeps software-side rules
`timescale 1ns/1ns
`default_nettype none
`include "pfcg_defs.svh"
module pfcg_periph_end
  import pfcg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link
  pfcg_if.per lnk,
  // user side sources
  input wire logic clk_mosc_i,
  input wire logic clk_adc_i,
  input wire logic clk_jtag_i,
  input wire logic clk_per_i,
  input wire logic clk_hsper_i,
  input wire logic pll_in_use_i,
  input wire logic timer3_input_select_i,
  input wire logic external_clock_source_select_i,
  input wire logic [9:0] gpio_peripheral_enable_i,
  input wire logic [9:0] pad_level_i,
  input wire logic [15:0] periph_drive_i,
  // user side results
  output logic [9:0] pad_out_o,
  output logic [9:0] pad_oe_o,
  output logic [5:0] clk_enable_o,
  output logic rate_violation_o
);
  logic [9:0] pad_out_reg;
  logic [9:0] pad_oe_reg;
  logic [5:0] clk_en_reg;
  logic viol_reg;
  logic viol_next;
  logic [9:0] pen;
  // pad b6 as clock source: nothing may drive it
  always_comb begin
    pen = gpio_peripheral_enable_i;
    pen[6] = pen[6] & ~external_clock_source_select_i;
  end
  assign lnk.clk_sys = clk_i;
  assign lnk.clk_mosc = clk_mosc_i;
  assign lnk.clk_adc = clk_adc_i;
  assign lnk.clk_jtag = clk_jtag_i;
  assign lnk.clk_per = clk_per_i;
  assign lnk.clk_hsper = clk_hsper_i;
  assign lnk.periph_en = pen;
  assign lnk.pad_in = pad_level_i;
  assign lnk.uart_tx = periph_drive_i[0];
  assign lnk.i2c_scl_out = 1'b0;
  assign lnk.i2c_scl_oe = periph_drive_i[1];
  assign lnk.i2c_sda_out = 1'b0;
  assign lnk.i2c_sda_oe = periph_drive_i[2];
  assign lnk.tmr_out = periph_drive_i[6:3];
  assign lnk.tmr_oe = periph_drive_i[10:7];
  assign lnk.pwm_out = periph_drive_i[12:11];
  assign lnk.spi_mosi_out = periph_drive_i[13];
  assign lnk.spi_mosi_oe = periph_drive_i[14];
  assign lnk.spi_miso_out = periph_drive_i[15];
  assign lnk.spi_miso_oe = ~periph_drive_i[14];
  assign lnk.spi_sclk_out = periph_drive_i[13];
  assign lnk.spi_sclk_oe = periph_drive_i[14];
  // flag illegal rate pairings seen on the link
  always_comb begin
    viol_next = 1'b0;
    if ((lnk.timer_rate_3x | lnk.pwm_rate_3x) & ~pll_in_use_i) begin
      viol_next = 1'b1;
    end
    if (timer3_input_select_i & lnk.pwm_rate_3x & ~lnk.timer_rate_3x) begin
      viol_next = 1'b1;
    end
  end
  // register results so outputs come from flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_out_reg <= 10'h000;
      pad_oe_reg <= 10'h000;
      clk_en_reg <= 6'h00;
      viol_reg <= 1'b0;
    end else begin
      pad_out_reg <= lnk.pad_out;
      pad_oe_reg <= lnk.pad_oe;
      clk_en_reg <= lnk.clk_enable;
      viol_reg <= viol_next;
    end
  end
  assign pad_out_o = pad_out_reg;
  assign pad_oe_o = pad_oe_reg;
  assign clk_enable_o = clk_en_reg;
  assign rate_violation_o = viol_reg;
endmodule // pfcg_periph_end
`default_nettype wire

// ==== test/pfcg_link_asserts.sv ====
// concurrent checks on the link between the device end and the peripheral end
`timescale 1ns/1ns
`default_nettype none
module pfcg_link_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pad side of the link
  input wire logic [9:0] periph_en,
  input wire logic [9:0] pad_out,
  input wire logic [9:0] pad_oe,
  // peripheral drives
  input wire logic uart_tx,
  input wire logic i2c_scl_out,
  input wire logic i2c_scl_oe,
  input wire logic i2c_sda_out,
  input wire logic i2c_sda_oe,
  input wire logic [3:0] tmr_out,
  input wire logic [3:0] tmr_oe,
  input wire logic [1:0] pwm_out,
  input wire logic spi_mosi_out,
  input wire logic spi_mosi_oe,
  // clock controls
  input wire logic [5:0] clk_enable,
  input wire logic timer_rate_3x,
  input wire logic pwm_rate_3x
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // out of reset every gate is shut and both rates are 1x
  sequence s_leave_reset;
    $rose(rst_n_i);
  endsequence
  sequence s_all_quiet;
    clk_enable == 6'h00 && !timer_rate_3x && !pwm_rate_3x;
  endsequence
  a_reset_all_off: assert property (s_leave_reset |-> s_all_quiet)
    else $error("gates or rates not cleared by reset");
  // gpio mode beats any peripheral choice
  a_gpio_pad_wins: assert property ((pad_oe & ~periph_en) == 10'h000)
    else $error("pad driven while in gpio mode");
  // driven pads b7, b3, a5 and a4 carry one of their two candidates, b5 and b1 their only one
  a_b7_uart_scl: assert property (pad_oe[7] |-> pad_out[7] == uart_tx ||
    (i2c_scl_oe && pad_out[7] == i2c_scl_out)) else $error("b7 drive mismatch");
  a_b5_timer_one: assert property (pad_oe[5] |-> tmr_oe[1] && pad_out[5] == tmr_out[1])
    else $error("b5 drive mismatch");
  a_b3_mosi_t3: assert property (pad_oe[3] |-> (spi_mosi_oe && pad_out[3] == spi_mosi_out) ||
    (tmr_oe[3] && pad_out[3] == tmr_out[3])) else $error("b3 drive mismatch");
  a_b1_sda_only: assert property (pad_oe[1] |-> i2c_sda_oe && pad_out[1] == i2c_sda_out)
    else $error("b1 drive mismatch");
  a_a5_pwm_t3: assert property (pad_oe[9] |-> pad_out[9] == pwm_out[1] ||
    (tmr_oe[3] && pad_out[9] == tmr_out[3])) else $error("a5 drive mismatch");
  a_a4_pwm_t2: assert property (pad_oe[8] |-> pad_out[8] == pwm_out[0] ||
    (tmr_oe[2] && pad_out[8] == tmr_out[2])) else $error("a4 drive mismatch");
endmodule // pfcg_link_asserts
`default_nettype wire

// ==== test/pin_function_and_clock_gate_tb_top.sv ====
// self-checking bench joining both ends of the pin function block
`timescale 1ns/1ns
`default_nettype none
module pin_function_and_clock_gate_tb_top;
  import pfcg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr = 1'b0, rd = 1'b0, cdis = 1'b1, pll = 1'b1, t3sel = 1'b1, xsel = 1'b0, rd_seen = 1'b0;
  pfcg_addr_t addr = 4'h0;
  pfcg_word_t wdat = 16'h0000, drv = 16'h0000, s, rdat;
  pfcg_clksel_t csel = 5'h00;
  logic [4:0] src = 5'h00;
  logic [6:0] ex;
  logic [9:0] gen = 10'h000, lvl = 10'h000;
  logic cko, viol;
  // registered copies from the peripheral end and what they should carry
  logic [9:0] poe_q, pout_q, oe_exp, out_exp;
  logic [5:0] cen_q;
  int miscompares = 0, n_compared = 0;
  int gpos[6] = '{0, 2, 4, 6, 13, 15};
  pfcg_clksel_t cs[7] = '{5'h00, 5'h09, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f};
  pfcg_word_t exp_q[$];
  // 25 MHz system clock
  always #20 clk_i = ~clk_i;
  pfcg_if lnk ();
  pfcg_device_end pfcg_device_end_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_rdata_o(rdat),
    .clock_out_select_i(csel), .clock_out_disable_i(cdis), .clock_out_signal_o(cko), .lnk(lnk));
  pfcg_periph_end pfcg_periph_end_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .lnk(lnk),
    .clk_mosc_i(src[0]), .clk_adc_i(src[1]), .clk_jtag_i(src[2]), .clk_per_i(src[3]),
    .clk_hsper_i(src[4]), .pll_in_use_i(pll), .timer3_input_select_i(t3sel),
    .external_clock_source_select_i(xsel), .gpio_peripheral_enable_i(gen),
    .pad_level_i(lvl), .periph_drive_i(drv), .pad_out_o(pout_q), .pad_oe_o(poe_q),
    .clk_enable_o(cen_q),
    .rate_violation_o(viol));
  pfcg_link_asserts pfcg_link_asserts_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .periph_en(lnk.periph_en), .pad_out(lnk.pad_out), .pad_oe(lnk.pad_oe),
    .uart_tx(lnk.uart_tx), .i2c_scl_out(lnk.i2c_scl_out), .i2c_scl_oe(lnk.i2c_scl_oe),
    .i2c_sda_out(lnk.i2c_sda_out), .i2c_sda_oe(lnk.i2c_sda_oe), .tmr_out(lnk.tmr_out),
    .tmr_oe(lnk.tmr_oe), .pwm_out(lnk.pwm_out), .spi_mosi_out(lnk.spi_mosi_out),
    .spi_mosi_oe(lnk.spi_mosi_oe), .clk_enable(lnk.clk_enable),
    .timer_rate_3x(lnk.timer_rate_3x), .pwm_rate_3x(lnk.pwm_rate_3x));
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one register cycle per call; a read notes its expected word, strobes stay until next call
  task automatic acc(input logic w, input logic r, input pfcg_addr_t a, input pfcg_word_t d);
    wr = w;
    rd = r;
    addr = a;
    wdat = d;
    if (r) exp_q.push_back(d);
    @(negedge clk_i);
  endtask
  // read data stands right after the taking edge, so look at the next falling edge
  always @(posedge clk_i) rd_seen <= rd;
  always @(negedge clk_i) begin
    if (rd_seen) cmp("rdata", exp_q.pop_front(), rdat);
  end
  // a peripheral input fed by two pads sees their or, only while some pad feeds it
  task automatic orin(input string nm, input logic g, input logic [1:0] m, input logic [1:0] p);
    if (m !== 2'b00) cmp(nm, {15'h0000, |(m & p)}, {15'h0000, g});
  endtask
  // expected pad drives worked out from the select word and the live peripheral drives
  task automatic chk_pads(input pfcg_word_t s);
    logic [9:0] o, e, pe, pi;
    pe = lnk.periph_en;
    pi = lnk.pad_in;
    {o[7], e[7]} = s[11] ? {lnk.i2c_scl_out, lnk.i2c_scl_oe} : {lnk.uart_tx, 1'b1};
    {o[6], e[6]} = s[10] ? {lnk.i2c_sda_out, lnk.i2c_sda_oe} : 2'b00;
    {o[5], e[5]} = s[9] ? 2'b00 : {lnk.tmr_out[1], lnk.tmr_oe[1]};
    {o[4], e[4]} = s[8] ? {cko, 1'b1} : {lnk.tmr_out[0], lnk.tmr_oe[0]};
    {o[3], e[3]} = s[7] ? {lnk.tmr_out[3], lnk.tmr_oe[3]} : {lnk.spi_mosi_out, lnk.spi_mosi_oe};
    {o[2], e[2]} = s[6] ? {lnk.tmr_out[2], lnk.tmr_oe[2]} : {lnk.spi_miso_out, lnk.spi_miso_oe};
    {o[1], e[1]} = s[5] ? {lnk.i2c_sda_out, lnk.i2c_sda_oe} : 2'b00;
    {o[0], e[0]} = s[4] ? {lnk.i2c_scl_out, lnk.i2c_scl_oe} : {lnk.spi_sclk_out, lnk.spi_sclk_oe};
    {o[9], e[9]} = s[3] ? (s[2] ? {lnk.tmr_out[3], lnk.tmr_oe[3]} : 2'b00) : {lnk.pwm_out[1], 1'b1};
    {o[8], e[8]} = s[1] ? (s[0] ? {lnk.tmr_out[2], lnk.tmr_oe[2]} : 2'b00) : {lnk.pwm_out[0], 1'b1};
    e = e & pe;
    cmp("pad_oe", {6'h00, e}, {6'h00, lnk.pad_oe});
    cmp("pad_out", {6'h00, o & e}, {6'h00, lnk.pad_out & e});
    cmp("b6_free", 16'h0000, {15'h0000, xsel & lnk.pad_oe[6]});
    orin("scl_in", lnk.i2c_scl_in, {s[11], s[4]} & {pe[7], pe[0]}, {pi[7], pi[0]});
    orin("sda_in", lnk.i2c_sda_in, {s[10], s[5]} & {pe[6], pe[1]}, {pi[6], pi[1]});
    orin("t3_in", lnk.tmr_in[3], {s[7], s[3:2] == 2'b11} & {pe[3], pe[9]}, {pi[3], pi[9]});
    orin("t2_in", lnk.tmr_in[2], {s[6], s[1:0] == 2'b11} & {pe[2], pe[8]}, {pi[2], pi[8]});
    // kept for the registered copies, which show up one cycle later
    oe_exp = e;
    out_exp = o & e;
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h08e8));
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    acc(1'b0, 1'b1, 4'h0b, 16'h0000);
    acc(1'b0, 1'b1, 4'h0c, 16'h0000);
    acc(1'b1, 1'b0, 4'h0b, 16'hffff);
    cmp("rates", 16'h0003, {14'h0000, lnk.timer_rate_3x, lnk.pwm_rate_3x});
    acc(1'b0, 1'b1, 4'h0b, 16'hcfff);
    acc(1'b1, 1'b0, 4'h0b, 16'h8000);
    cmp("rates", 16'h0002, {14'h0000, lnk.timer_rate_3x, lnk.pwm_rate_3x});
    acc(1'b1, 1'b0, 4'h0b, 16'h0000);
    cmp("rates", 16'h0000, {14'h0000, lnk.timer_rate_3x, lnk.pwm_rate_3x});
    acc(1'b1, 1'b0, 4'h0c, 16'hffff);
    acc(1'b0, 1'b1, 4'h0c, 16'ha055);
    acc(1'b1, 1'b0, 4'h03, 16'hffff);
    acc(1'b0, 1'b1, 4'h03, 16'h0000);
    // each gate alone, reserved neighbours untouched
    for (int i = 0; i < 6; i++) begin
      // peripheral drives stay idle while their gates change
      acc(1'b1, 1'b0, 4'h0c, 16'h0001 << gpos[i]);
      cmp("clk_en", {10'h000, 6'h01 << i}, {10'h000, lnk.clk_enable});
      acc(1'b0, 1'b1, 4'h0c, 16'h0001 << gpos[i]);
      cmp("clk_en_q", {10'h000, 6'h01 << i}, {10'h000, cen_q});
    end
    // drop the read strobe, else every idle cycle would take another read
    acc(1'b0, 1'b0, 4'h00, 16'h0000);
    // every clock-out code, disabled and enabled (sys code checked only disabled), with random source levels
    for (int i = 0; i < 7; i++) begin
      for (int k = 0; k < 2; k++) begin
        csel = cs[i];
        src = 5'($urandom);
        cdis = k[0];
        repeat (2) @(negedge clk_i);
        ex = {src[4], ~src[3], src[3], src[2], src[1], src[0], 1'b0};
        if (cdis || i > 0) cmp("clk_out", {15'h0000, cdis ? 1'b0 : ex[i]}, {15'h0000, cko});
      end
    end
    // an unlisted code gives a quiet clock output
    csel = 5'h01;
    cdis = 1'b0;
    src = 5'h1f;
    repeat (2) @(negedge clk_i);
    cmp("clk_out", 16'h0000, {15'h0000, cko});
    cdis = 1'b1;
    // random pad routing with random enables, levels and peripheral drives
    for (int i = 0; i < 60; i++) begin
      gen = 10'($urandom);
      lvl = 10'($urandom);
      drv = 16'($urandom);
      xsel = 1'($urandom);
      s = 16'($urandom) & 16'h0fff;
      acc(1'b1, 1'b0, 4'h0b, s);
      chk_pads(s);
      acc(1'b0, 1'b1, 4'h0b, s);
      cmp("pad_oe_q", {6'h00, oe_exp}, {6'h00, poe_q});
      cmp("pad_out_q", {6'h00, out_exp}, {6'h00, pout_q & oe_exp});
    end
    // pwm 3x with timer 1x on the reload path must be flagged, then clear again
    acc(1'b1, 1'b0, 4'h0b, 16'h4000);
    acc(1'b0, 1'b1, 4'h0b, 16'h4000);
    cmp("rate_bad", 16'h0001, {15'h0000, viol});
    acc(1'b1, 1'b0, 4'h0b, 16'h0000);
    acc(1'b0, 1'b0, 4'h00, 16'h0000);
    cmp("rate_bad", 16'h0000, {15'h0000, viol});
    // second reset in mid-run clears both registers
    rst_n_i = 1'b0;
    acc(1'b0, 1'b0, 4'h00, 16'h0000);
    rst_n_i = 1'b1;
    acc(1'b0, 1'b1, 4'h0b, 16'h0000);
    acc(1'b0, 1'b1, 4'h0c, 16'h0000);
    acc(1'b0, 1'b0, 4'h00, 16'h0000);
    acc(1'b0, 1'b0, 4'h00, 16'h0000);
    wrap_up();
  end
  // hang guard, far beyond the length of the sequence
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    wrap_up();
  end
endmodule // pin_function_and_clock_gate_tb_top
`default_nettype wire
